// ===== hw/cpm_top.sv
// Parameter map of a process controller reached by identifier code.
// Assumes a message decoder on clk delivers one request per pulse
// and that process values and fault conditions come from clk logic.
//
// Operation
// - Analog ids 1..114 written by host start a non-volatile write at once.
// - Overrides 120, 123, 125 live only in volatile registers.
// - Digital ids 128..250 except 157, 167, 185 written by host update non-volatile memory at once.
// - Ids 118..122 read inputs, process value, remote value, combined; writes error except 120 in slave mode.
// - Reading id 122 answers once with process value, setpoint and output.
// - Id 185 reads the option mask 0..255, one bit per option.
// - Ids 157 type and 167 version are read-only; writes are rejected.
// - Id 255 weights: 1 manual, 2 failsafe, 4 work cal, 8 config, 16 factory.
// - Weight 32 hardware failure, 64 restart after shed, 128 memory changed.
// - Simultaneous faults read as the sum of their weights.
// - Any write to id 255 clears the status; next read gives zero unless a source is still active.
// - Digital id 174 holds setpoint ramp minutes and accepts writes.
`include "cpm_map.svh"

module cpm_top #(
   parameter int         WIDTH       = 16,
   parameter logic [7:0] SW_TYPE     = 8'h5A,  // Arbitrary value
   parameter logic [7:0] SW_REVISION = 8'h01   // Arbitrary value
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  cpm_pkg::cpm_req_s     req,
   output cpm_pkg::cpm_rsp_s     rsp,
   output cpm_pkg::cpm_nvm_s     nvm,
   input  wire logic             slave_mode,
   input  wire logic [WIDTH-1:0] input1,
   input  wire logic [WIDTH-1:0] input2,
   input  wire logic [WIDTH-1:0] process_value,
   input  wire logic [WIDTH-1:0] remote_value_internal,
   input  wire logic [WIDTH-1:0] setpoint,
   input  wire logic [WIDTH-1:0] output_value,
   input  wire logic [7:0]       option_presence_mask,
   input  wire logic [4:0]       fault_cond,
   input  wire logic             hw_fail,
   input  wire logic             shed_restart,
   input  wire logic             mem_changed,
   output logic                  proc_ovr_active,
   output logic      [WIDTH-1:0] proc_ovr,
   output logic                  out_ovr_active,
   output logic      [WIDTH-1:0] out_ovr,
   output logic                  csp_ovr_active,
   output logic      [WIDTH-1:0] csp_ovr
);

   cpm_pkg::cpm_kind_e kind;
   cpm_pkg::cpm_rsp_s  next_rsp;
   cpm_pkg::cpm_nvm_s  next_nvm;
   logic [WIDTH-1:0]   store_rd;
   logic               store_we;
   logic [7:0]         fault_status_flags;
   logic               fault_clear;
   logic               is_wr;
   logic               is_rd;

   logic               next_proc_act;
   logic               next_out_act;
   logic               next_csp_act;
   logic [WIDTH-1:0]   next_proc_ovr;
   logic [WIDTH-1:0]   next_out_ovr;
   logic [WIDTH-1:0]   next_csp_ovr;

   // ------------------------------------------------------------
   // Identifier classification
   // ------------------------------------------------------------
   // Read-only ids inside the digital range are caught first so that
   // they never reach the store
   // Classes by id:
   //   1..114       analog, committed
   //   118..122     live data, writes refused
   //   120          process value override
   //   123, 125     output, setpoint override
   //   128..250     digital, committed
   //   157,167,185  read-only
   //   255          fault status
   //   others       unmapped, error
   function automatic cpm_pkg::cpm_kind_e classify(input logic [7:0] id);
      cpm_pkg::cpm_kind_e k;
      k = cpm_pkg::CPM_K_UNMAPPED;
      if (id == `CPM_ID_SW_TYPE || id == `CPM_ID_SW_REV || id == `CPM_ID_OPTIONS) begin
         k = cpm_pkg::CPM_K_RO_CONST;
      end else if (id == `CPM_ID_FAULTS) begin
         k = cpm_pkg::CPM_K_FAULT;
      end else if (id >= `CPM_ID_ANALOG_LO && id <= `CPM_ID_ANALOG_HI) begin
         k = cpm_pkg::CPM_K_ANALOG;
      end else if (id >= `CPM_ID_DIGITAL_LO && id <= `CPM_ID_DIGITAL_HI) begin
         k = cpm_pkg::CPM_K_DIGITAL;
      end else if (id == `CPM_ID_OUT_OVR || id == `CPM_ID_CSP_OVR) begin
         k = cpm_pkg::CPM_K_OVERRIDE;
      end else if (id >= `CPM_ID_INPUT1 && id <= `CPM_ID_COMBINED) begin
         k = cpm_pkg::CPM_K_CONTROL;
      end
      return k;
   endfunction

   // Decode shared by all sections
   assign kind  = classify(req.id);
   assign is_wr = req.valid && req.write;
   assign is_rd = req.valid && !req.write;

   // ------------------------------------------------------------
   // Storable parameters
   // ------------------------------------------------------------
   // Only analog and digital configuration words enter the store;
   // control and read-only ids never write it
   // One word per id: no index translation,
   // at the cost of unused entries.
   // Unwritten words read as zero.
   assign store_we = is_wr && (kind == cpm_pkg::CPM_K_ANALOG
                            || kind == cpm_pkg::CPM_K_DIGITAL);

   cpm_param_store #(
      .DEPTH (256),
      .WIDTH (WIDTH)
   ) u_store (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (store_we),
      .wr_id   (req.id),
      .wr_data (req.data),
      .rd_id   (req.id),
      .rd_data (store_rd)
   );

   // ------------------------------------------------------------
   // Fault status
   // ------------------------------------------------------------
   // Any data value clears; the data word is not looked at
   // A commit counts as a memory change too.
   // A source still active while clearing
   // sets its bit again.
   assign fault_clear = is_wr && (kind == cpm_pkg::CPM_K_FAULT);

   cpm_fault_status u_faults (
      .clk          (clk),
      .rst_n        (rst_n),
      .cond         (fault_cond),
      .hw_fail      (hw_fail),
      .shed_restart (shed_restart),
      .mem_changed  (mem_changed | nvm.start),
      .clear        (fault_clear),
      .status       (fault_status_flags)
   );

   // ------------------------------------------------------------
   // Non-volatile commit strobe
   // ------------------------------------------------------------
   // Issued the cycle after the message, with the new word, so the
   // memory controller starts its write cycle without delay
   // Nothing queues commits: the memory
   // controller must take each strobe at once.
   // Back-to-back writes, back-to-back strobes.
   always_comb begin
      next_nvm = '0;
      if (store_we) begin
         next_nvm.start = 1'b1;
         next_nvm.id    = req.id;
         next_nvm.data  = req.data;
      end
   end

   // One pulse per accepted word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvm <= '0;
      end else begin
         nvm <= next_nvm;
      end
   end

   // ------------------------------------------------------------
   // Volatile overrides
   // ------------------------------------------------------------
   // Never routed to the commit strobe, so rewrites cost no endurance.
   // Leaving slave mode drops every override.
   // No shed timer here; slave_mode carries
   // that decision. Reads of an override id
   // show the override while it is active.
   always_comb begin
      next_proc_act = proc_ovr_active && slave_mode;
      next_out_act  = out_ovr_active && slave_mode;
      next_csp_act  = csp_ovr_active && slave_mode;
      next_proc_ovr = proc_ovr;
      next_out_ovr = out_ovr;
      next_csp_ovr = csp_ovr;
      if (is_wr && slave_mode) begin
         if (req.id == `CPM_ID_PROC_VAL) begin
            next_proc_act = 1'b1;
            next_proc_ovr = req.data;
         end
         if (req.id == `CPM_ID_OUT_OVR) begin
            next_out_act = 1'b1;
            next_out_ovr = req.data;
         end
         if (req.id == `CPM_ID_CSP_OVR) begin
            next_csp_act = 1'b1;
            next_csp_ovr = req.data;
         end
      end
   end

   // Override values and active flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         proc_ovr_active <= 1'b0;
         out_ovr_active  <= 1'b0;
         csp_ovr_active  <= 1'b0;
         proc_ovr        <= '0;
         out_ovr         <= '0;
         csp_ovr         <= '0;
      end else begin
         proc_ovr_active <= next_proc_act;
         out_ovr_active  <= next_out_act;
         csp_ovr_active  <= next_csp_act;
         proc_ovr        <= next_proc_ovr;
         out_ovr         <= next_out_ovr;
         csp_ovr         <= next_csp_ovr;
      end
   end

   // ------------------------------------------------------------
   // Answer formation
   // ------------------------------------------------------------
   // Every request gets exactly one answer one cycle later
   // Built from the request alone: no stall.
   // Refusals still carry the addressed
   // value; unmapped ids answer zero.
   always_comb begin
      next_rsp = '0;
      next_rsp.valid = req.valid;
      case (kind)
         cpm_pkg::CPM_K_ANALOG,
         cpm_pkg::CPM_K_DIGITAL: begin
            // Read of 174 gives the ramp minutes held in the store
            next_rsp.data0 = is_rd ? store_rd : req.data;
         end
         cpm_pkg::CPM_K_OVERRIDE: begin
            // Override reads echo the volatile value while active, else the live value
            if (req.id == `CPM_ID_OUT_OVR) begin
               next_rsp.data0 = out_ovr_active ? out_ovr : output_value;
            end else begin
               next_rsp.data0 = csp_ovr_active ? csp_ovr : setpoint;
            end
            next_rsp.error = is_wr && !slave_mode;
         end
         cpm_pkg::CPM_K_CONTROL: begin
            // Live values, held by the answer flop
            case (req.id)
               `CPM_ID_INPUT1: next_rsp.data0 = input1;
               `CPM_ID_INPUT2: next_rsp.data0 = input2;
               `CPM_ID_PROC_VAL: next_rsp.data0 = proc_ovr_active ? proc_ovr : process_value;
               `CPM_ID_REMOTE:   next_rsp.data0 = remote_value_internal;
               `CPM_ID_COMBINED: begin
                  next_rsp.triple = 1'b1;
                  next_rsp.data0  = proc_ovr_active ? proc_ovr : process_value;
                  next_rsp.data1  = setpoint;
                  next_rsp.data2  = output_value;
               end
               default: next_rsp.data0 = '0;
            endcase
            // Process value takes a write only as a slave-mode override
            next_rsp.error = is_wr && !(req.id == `CPM_ID_PROC_VAL && slave_mode);
         end
         cpm_pkg::CPM_K_RO_CONST: begin
            // Refusal only; no stored word moves
            case (req.id)
               `CPM_ID_SW_TYPE: next_rsp.data0 = WIDTH'(SW_TYPE);
               `CPM_ID_SW_REV:  next_rsp.data0 = WIDTH'(SW_REVISION);
               default:         next_rsp.data0 = WIDTH'(option_presence_mask);
            endcase
            next_rsp.error = is_wr;
         end
         cpm_pkg::CPM_K_FAULT: begin
            // Bits are binary weights, so the word is already their sum
            next_rsp.data0 = WIDTH'(fault_status_flags);
         end
         default: begin
            // Unmapped: error on read and write
            next_rsp.error = req.valid;
         end
      endcase
      if (!req.valid) begin
         next_rsp = '0;
      end
   end

   // Answer register, one cycle per request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end

endmodule

// ===== hw/cpm_map.svh
// Identifier codes, field positions, reset values and timing of the parameter map.
// Assumes inclusion from the package and design files by bare name.
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

// ------------------------------------------------------------
// Identifier ranges and single codes
// ------------------------------------------------------------
`define CPM_ID_ANALOG_LO   8'h01
`define CPM_ID_ANALOG_HI   8'h72
`define CPM_ID_INPUT1      8'h76
`define CPM_ID_INPUT2      8'h77
`define CPM_ID_PROC_VAL    8'h78
`define CPM_ID_REMOTE      8'h79
`define CPM_ID_COMBINED    8'h7A
`define CPM_ID_OUT_OVR     8'h7B
`define CPM_ID_CSP_OVR     8'h7D
`define CPM_ID_DIGITAL_LO  8'h80
`define CPM_ID_DIGITAL_HI  8'hFA
`define CPM_ID_SW_TYPE     8'h9D
`define CPM_ID_SW_REV      8'hA7
`define CPM_ID_RAMP_TIME   8'hAE
`define CPM_ID_OPTIONS     8'hB9
`define CPM_ID_FAULTS      8'hFF

// ------------------------------------------------------------
// Fault status bit positions (weight = 2**position)
// ------------------------------------------------------------
`define CPM_FLT_EMERG_MAN  0
`define CPM_FLT_FAILSAFE   1
`define CPM_FLT_WORK_CAL   2
`define CPM_FLT_CFG_SUM    3
`define CPM_FLT_FACT_CAL   4
`define CPM_FLT_HW_FAIL    5
`define CPM_FLT_SHED       6
`define CPM_FLT_MEM_CHG    7
`define CPM_FLT_RESET      8'h00

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define CPM_PARAM_RESET    16'h0000
`define CPM_ANSWER_CYCLES  1

`endif

// ===== hw/cpm_pkg.sv
// Types shared by the parameter map design files.
// Assumes cpm_map.svh is on the include path.
`include "cpm_map.svh"

package cpm_pkg;

   // ---------------------------------------------------------
   // Identifier classes
   // ---------------------------------------------------------
   typedef enum logic [2:0] {
      CPM_K_UNMAPPED = 3'b000,
      CPM_K_ANALOG   = 3'b001,
      CPM_K_DIGITAL  = 3'b010,
      CPM_K_OVERRIDE = 3'b011,
      CPM_K_CONTROL  = 3'b100,
      CPM_K_RO_CONST = 3'b101,
      CPM_K_FAULT    = 3'b110
   } cpm_kind_e;

   // ---------------------------------------------------------
   // Host request and device answer
   // ---------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  id;
      logic [15:0] data;
   } cpm_req_s;

   typedef struct packed {
      logic        valid;
      logic        error;
      logic        triple;
      logic [15:0] data0;
      logic [15:0] data1;
      logic [15:0] data2;
   } cpm_rsp_s;

   // Commit strobe toward the non-volatile memory controller
   typedef struct packed {
      logic        start;
      logic [7:0]  id;
      logic [15:0] data;
   } cpm_nvm_s;

endpackage

// ===== hw/cpm_param_store.sv
// Mirror of the storable parameters, one word per identifier.
// Assumes a single writer per cycle; read data is combinational.
`include "cpm_map.svh"

module cpm_param_store #(
   parameter int DEPTH = 256,
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             wr_en,
   input  wire logic [7:0]       wr_id,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [7:0]       rd_id,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];

   // ------------------------------------------------------------
   // One word per entry
   // ------------------------------------------------------------
   for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      // Entry takes the write only when addressed
      always_comb begin
         next_mem[g] = mem[g];
         if (wr_en && (wr_id == 8'(g))) begin
            next_mem[g] = wr_data;
         end
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            mem[g] <= WIDTH'(`CPM_PARAM_RESET);
         end else begin
            mem[g] <= next_mem[g];
         end
      end
   end

   // Out of range ids read zero instead of indexing past the array
   assign rd_data = (int'(rd_id) < DEPTH) ? mem[rd_id] : '0;

endmodule

// ===== hw/cpm_fault_status.sv
// Eight-bit sticky fault status with clear-on-write.
// Assumes all condition inputs are on clk; pulses are one cycle.
`include "cpm_map.svh"

module cpm_fault_status (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [4:0] cond,
   input  wire logic       hw_fail,
   input  wire logic       shed_restart,
   input  wire logic       mem_changed,
   input  wire logic       clear,
   output logic      [7:0] status
);

   logic [7:0] next_status;
   logic [4:0] cond_q;
   logic [4:0] next_cond_q;
   logic [7:0] set_vec;

   // ------------------------------------------------------------
   // Set and clear of the sticky flags
   // ------------------------------------------------------------
   // Setting wins over a clear in the same cycle so no event is lost
   always_comb begin
      next_cond_q = cond;
      set_vec = '0;
      set_vec[4:0] = cond;
      set_vec[`CPM_FLT_HW_FAIL] = hw_fail;
      set_vec[`CPM_FLT_SHED] = shed_restart;
      set_vec[`CPM_FLT_MEM_CHG] = mem_changed | (|(cond ^ cond_q));
      next_status = clear ? set_vec : (status | set_vec);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= `CPM_FLT_RESET;
         cond_q <= '0;
      end else begin
         status <= next_status;
         cond_q <= next_cond_q;
      end
   end

endmodule

// ===== tb/cpm_top_properties.sv
// Concurrent checks on the ports of the parameter map.
// Assumes binding into cpm_top; one clock, asynchronous active-low reset.
`include "cpm_map.svh"

module cpm_top_properties #(
   parameter logic [7:0] SW_TYPE = 8'h5A  // Arbitrary value
) (
   input wire logic         clk,
   input wire logic         rst_n,
   input cpm_pkg::cpm_req_s req,
   input cpm_pkg::cpm_rsp_s rsp,
   input cpm_pkg::cpm_nvm_s nvm,
   input wire logic [15:0]  setpoint,
   input wire logic [15:0]  output_value,
   input wire logic [7:0]   option_presence_mask,
   input wire logic [4:0]   fault_cond,
   input wire logic         hw_fail,
   input wire logic         shed_restart,
   input wire logic         mem_changed
);
   // ----
   // Request decode helpers
   // ----
   logic wr;
   logic rd;
   logic quiet;
   assign wr = req.valid && req.write;
   assign rd = req.valid && !req.write;
   // No fault source may set a bit while a clear is judged
   assign quiet = (fault_cond == 5'h00) && !hw_fail && !shed_restart && !mem_changed
                  && !nvm.start;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Clear, one idle cycle, then a read of the status
   sequence clear_s;
      wr && req.id == `CPM_ID_FAULTS && quiet && $stable(fault_cond) ##1
      !req.valid && quiet ##1 rd && req.id == `CPM_ID_FAULTS && quiet;
   endsequence

   answer_follows_a: assert property (req.valid |=> rsp.valid)
      else $error("request without answer");
   answer_single_a: assert property (!req.valid |=> !rsp.valid)
      else $error("answer without request");
   analog_commit_a: assert property (wr && req.id inside {[`CPM_ID_ANALOG_LO:`CPM_ID_ANALOG_HI]}
      |=> nvm.start && nvm.id == $past(req.id) && nvm.data == $past(req.data))
      else $error("analog write not committed");
   digital_commit_a: assert property (wr && req.id inside {[`CPM_ID_DIGITAL_LO:`CPM_ID_DIGITAL_HI]}
      && !(req.id inside {`CPM_ID_SW_TYPE, `CPM_ID_SW_REV, `CPM_ID_OPTIONS})
      |=> nvm.start && !rsp.error && nvm.id == $past(req.id))
      else $error("digital write not committed");
   override_volatile_a: assert property (wr && req.id inside {`CPM_ID_PROC_VAL, `CPM_ID_OUT_OVR,
      `CPM_ID_CSP_OVR} |=> !nvm.start)
      else $error("override reached memory");
   control_write_err_a: assert property (wr && req.id inside {`CPM_ID_INPUT1, `CPM_ID_INPUT2,
      `CPM_ID_REMOTE, `CPM_ID_COMBINED} |=> rsp.error && !nvm.start)
      else $error("control write accepted");
   triple_read_a: assert property (rd && req.id == `CPM_ID_COMBINED |=> rsp.triple
      && rsp.data1 == $past(setpoint) && rsp.data2 == $past(output_value))
      else $error("combined read wrong");
   option_read_a: assert property (rd && req.id == `CPM_ID_OPTIONS
      |=> rsp.data0 == {8'h00, $past(option_presence_mask)})
      else $error("option mask read wrong");
   readonly_reject_a: assert property (wr && req.id inside {`CPM_ID_SW_TYPE, `CPM_ID_SW_REV,
      `CPM_ID_OPTIONS} |=> rsp.error && !nvm.start)
      else $error("read-only write accepted");
   type_read_a: assert property (rd && req.id == `CPM_ID_SW_TYPE
      |=> rsp.data0 == {8'h00, SW_TYPE})
      else $error("type code read wrong");
   status_clear_a: assert property (clear_s |=> rsp.data0 == 16'h0000)
      else $error("status not cleared");
endmodule

bind cpm_top cpm_top_properties #(.SW_TYPE(SW_TYPE)) u_props (
   .clk(clk),
   .rst_n(rst_n),
   .req(req),
   .rsp(rsp),
   .nvm(nvm),
   .setpoint(setpoint),
   .output_value(output_value),
   .option_presence_mask(option_presence_mask),
   .fault_cond(fault_cond),
   .hw_fail(hw_fail),
   .shed_restart(shed_restart),
   .mem_changed(mem_changed)
);

// ===== tb/cpm_host_model.sv
// Host side of the parameter map: issues one request per call.
// Assumes the answer stands in the cycle after the accepting edge.
module cpm_host_model (
   input  wire logic         clk,
   output cpm_pkg::cpm_req_s req,
   input  cpm_pkg::cpm_rsp_s rsp
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req = '{valid: 1'b0, write: 1'b0, id: 8'h00, data: 16'h0000};

   // ----
   // One transfer; answer taken at the next falling edge
   // ----
   task automatic xfer(input logic wr, input logic [7:0] id, input logic [15:0] data,
                       output cpm_pkg::cpm_rsp_s ans);
      @(negedge clk);
      req <= '{valid: 1'b1, write: wr, id: id, data: data};
      @(negedge clk);
      ans = rsp;
      // Idle fields flip so a stale request never looks live
      req <= '{valid: 1'b0, write: ~wr, id: ~id, data: ~data};
   endtask
endmodule

// ===== tb/test_controller_parameter_map.sv
// Self-checking bench for the parameter map.
// Assumes the design files and cpm_map.svh are compiled alongside.
`include "cpm_map.svh"

`define CHECK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); \
      end \
   end

module test_controller_parameter_map;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] SW_TYPE = 8'h5A;  // Arbitrary value
   localparam logic [7:0] SW_REV  = 8'h01;  // Arbitrary value

   logic              clk;
   logic              rst_n;
   logic              slave_mode;
   logic              hw_fail;
   logic              shed_restart;
   logic              mem_changed;
   logic [15:0]       live [6];
   logic [7:0]        option_presence_mask;
   logic [4:0]        fault_cond;
   logic [2:0]        ovr_on;
   logic [15:0]       ovr [3];
   cpm_pkg::cpm_req_s req;
   cpm_pkg::cpm_rsp_s rsp;
   cpm_pkg::cpm_rsp_s ans;
   cpm_pkg::cpm_nvm_s nvm;
   int                n_errors = 0;
   int                samples_checked = 0;

   cpm_top #(.SW_TYPE(SW_TYPE), .SW_REVISION(SW_REV)) dut (
      .clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .nvm(nvm), .slave_mode(slave_mode),
      .input1(live[0]), .input2(live[1]), .process_value(live[2]),
      .remote_value_internal(live[3]), .setpoint(live[4]), .output_value(live[5]),
      .option_presence_mask(option_presence_mask), .fault_cond(fault_cond),
      .hw_fail(hw_fail), .shed_restart(shed_restart), .mem_changed(mem_changed),
      .proc_ovr_active(ovr_on[0]), .proc_ovr(ovr[0]), .out_ovr_active(ovr_on[1]),
      .out_ovr(ovr[1]), .csp_ovr_active(ovr_on[2]), .csp_ovr(ovr[2]));

   cpm_host_model host (.clk(clk), .req(req), .rsp(rsp));

   // ----
   // Shared transfers
   // ----
   task automatic wr_chk(input logic [7:0] id, input logic [15:0] d, input logic err,
                         input logic commit);
      host.xfer(1'b1, id, d, ans);
      `CHECK(ans.error, err)
      `CHECK(nvm.start, commit)
      if (commit) `CHECK(nvm.id, id)
   endtask

   task automatic rd_chk(input logic [7:0] id, input logic [15:0] exp);
      host.xfer(1'b0, id, 16'h0000, ans);
      `CHECK(ans.valid, 1'b1)
      `CHECK(ans.data0, exp)
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_ranges;
      wr_chk(`CPM_ID_RAMP_TIME, 16'h003C, 1'b0, 1'b1);
      `CHECK(nvm.data, 16'h003C)
      rd_chk(`CPM_ID_RAMP_TIME, 16'h003C);
      wr_chk(`CPM_ID_ANALOG_LO, 16'h0011, 1'b0, 1'b1);
      wr_chk(`CPM_ID_ANALOG_HI, 16'h0022, 1'b0, 1'b1);
      wr_chk(8'h73, 16'h0033, 1'b1, 1'b0);
      wr_chk(`CPM_ID_DIGITAL_HI, 16'h0055, 1'b0, 1'b1);
      wr_chk(8'hFB, 16'h0066, 1'b1, 1'b0);
      rd_chk(`CPM_ID_ANALOG_HI, 16'h0022);
      $display("range test done");
   endtask

   task automatic t_read_only;
      option_presence_mask = 8'hA5;
      wr_chk(`CPM_ID_SW_TYPE, 16'h00FF, 1'b1, 1'b0);
      wr_chk(`CPM_ID_SW_REV, 16'h00FF, 1'b1, 1'b0);
      wr_chk(`CPM_ID_OPTIONS, 16'h00FF, 1'b1, 1'b0);
      rd_chk(`CPM_ID_SW_TYPE, {8'h00, SW_TYPE});
      rd_chk(`CPM_ID_SW_REV, {8'h00, SW_REV});
      rd_chk(`CPM_ID_OPTIONS, 16'h00A5);
      $display("read-only test done");
   endtask

   task automatic t_control;
      logic [7:0] ids [5];
      ids = '{`CPM_ID_INPUT1, `CPM_ID_INPUT2, `CPM_ID_PROC_VAL, `CPM_ID_REMOTE, `CPM_ID_COMBINED};
      for (int i = 0; i < 4; i++) begin
         rd_chk(ids[i], live[i]);
      end
      // Slave mode is off, so the process value override is refused as well
      for (int i = 0; i < 5; i++) begin
         wr_chk(ids[i], 16'h0BAD, 1'b1, 1'b0);
      end
      rd_chk(`CPM_ID_COMBINED, live[2]);
      `CHECK({ans.triple, ans.data1, ans.data2}, {1'b1, live[4], live[5]})
      $display("control data test done");
   endtask

   task automatic t_override;
      wr_chk(`CPM_ID_CSP_OVR, 16'h0123, 1'b1, 1'b0);
      slave_mode = 1'b1;
      wr_chk(`CPM_ID_CSP_OVR, 16'h0123, 1'b0, 1'b0);
      wr_chk(`CPM_ID_OUT_OVR, 16'h0789, 1'b0, 1'b0);
      wr_chk(`CPM_ID_PROC_VAL, 16'h0456, 1'b0, 1'b0);
      `CHECK({ovr_on, ovr[0], ovr[1], ovr[2]}, {3'b111, 16'h0456, 16'h0789, 16'h0123})
      rd_chk(`CPM_ID_OUT_OVR, 16'h0789);
      rd_chk(`CPM_ID_CSP_OVR, 16'h0123);
      rd_chk(`CPM_ID_COMBINED, 16'h0456);
      slave_mode = 1'b0;
      repeat (2) @(negedge clk);
      `CHECK(ovr_on, 3'b000)
      rd_chk(`CPM_ID_CSP_OVR, live[4]);
      $display("override test done");
   endtask

   task automatic t_faults;
      wr_chk(`CPM_ID_FAULTS, 16'h1234, 1'b0, 1'b0);
      rd_chk(`CPM_ID_FAULTS, 16'h0000);
      // A change of any level condition also flags a memory change
      for (int i = 0; i < 5; i++) begin
         fault_cond = 5'(1 << i);
         @(negedge clk);
         fault_cond = 5'h00;
         rd_chk(`CPM_ID_FAULTS, {8'h00, 8'h80 | 8'(1 << i)});
         wr_chk(`CPM_ID_FAULTS, 16'h0000, 1'b0, 1'b0);
      end
      hw_fail = 1'b1;
      @(negedge clk);
      hw_fail = 1'b0;
      rd_chk(`CPM_ID_FAULTS, 16'h0020);
      wr_chk(`CPM_ID_FAULTS, 16'h00FF, 1'b0, 1'b0);
      shed_restart = 1'b1;
      mem_changed = 1'b1;
      @(negedge clk);
      shed_restart = 1'b0;
      mem_changed = 1'b0;
      rd_chk(`CPM_ID_FAULTS, 16'h00C0);
      wr_chk(`CPM_ID_FAULTS, 16'h5A5A, 1'b0, 1'b0);
      rd_chk(`CPM_ID_FAULTS, 16'h0000);
      $display("fault status test done");
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----
   // Clock, reset, sequence and watchdog
   // ----
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      slave_mode = 1'b0;
      hw_fail = 1'b0;
      shed_restart = 1'b0;
      mem_changed = 1'b0;
      fault_cond = 5'h00;
      option_presence_mask = 8'h00;
      live = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666};
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      t_ranges;
      t_read_only;
      t_control;
      t_override;
      t_faults;
      finish_test;
   end

   // Tests need well under a microsecond; allow a wide margin
   initial begin
      #20000;
      n_errors++;
      finish_test;
   end
endmodule
